/* File: shared/cktm_pkg.sv */
`default_nettype none
// ****************************************
// clock timer constants
// ****************************************
package cktm_pkg;
   localparam int IDX_W = 16;
   localparam int ADDR_W = IDX_W + 2;
   localparam int DATA_W = 32;
   // register indices, byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_TIMER_CONTROL = 16'hff74;
   localparam logic [IDX_W-1:0] IDX_TIMER_COUNT_LOW = 16'hff75;
   localparam logic [IDX_W-1:0] IDX_TIMER_COUNT_HIGH = 16'hff76;
   localparam logic [IDX_W-1:0] IDX_TIMER_IRQ_ENABLE = 16'hffe5;
   localparam logic [IDX_W-1:0] IDX_TIMER_IRQ_FLAGS = 16'hfff5;
   // control fields
   localparam int CTRL_RUN_BIT = 0;
   localparam int CTRL_CLEAR_BIT = 1;
   // counter taps feeding events: 32 Hz, 8 Hz, 2 Hz, 1 Hz
   localparam int TAP_32HZ = 2;
   localparam int TAP_8HZ = 4;
   localparam int TAP_2HZ = 6;
   localparam int TAP_1HZ = 7;
   // reset values
   localparam logic [7:0] COUNT_RST = 8'h00;
   localparam logic [3:0] NIBBLE_RST = 4'h0;
   localparam logic [3:0] NIBBLE_MAX = 4'hf;
   localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h0000_0000;
   // timing
   localparam int CLK_MHZ = 200;
   localparam int TICK_HZ = 256;
   localparam int HOLD_MIN_US = 480;
   localparam int HOLD_MAX_US = 1500;
   localparam int TICK_CYC_DEF = (CLK_MHZ * 1000000) / TICK_HZ;
   localparam int HOLD_CYC_DEF = HOLD_MIN_US * CLK_MHZ;
   localparam int HOLD_CYC_MAX = HOLD_MAX_US * CLK_MHZ;
endpackage
`default_nettype wire

/* File: logic/cktm_tick_div.sv */
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// count-clock divider: one-cycle tick per period
// ****************************************
module cktm_tick_div
   import cktm_pkg::*;
#(
   parameter int DIV = TICK_CYC_DEF
)
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // control
   input wire logic restart,
   // tick out
   output logic tick
);
   localparam int CW = $clog2(DIV);
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);
   localparam logic [CW-1:0] ZERO = '0;

   logic [CW-1:0] cnt_r;

   generate
      if (DIV < 2)
      begin : g_chk
         $error("cktm_tick_div: DIV must be at least 2");
      end
   endgenerate

   // restart realigns the phase so a cleared timer starts a full period
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cnt_r <= '0;
      else if (restart || cnt_r == LAST)
         cnt_r <= ZERO;
      else
         cnt_r <= cnt_r + 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         tick <= 1'b0;
      else
         tick <= !restart && cnt_r == LAST;
   end
endmodule
`default_nettype wire

/* File: logic/cktm_clock_timer.sv */
`timescale 1ns/10ps
`default_nettype none
module cktm_clock_timer
   import cktm_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYC_DEF,
   parameter int HOLD_CYC = HOLD_CYC_DEF
)
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [DATA_W-1:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // timer outputs
   output logic timer_irq,
   output logic [7:0] count_bits
);
   localparam int HW = $clog2(HOLD_CYC + 1);
   localparam logic [HW-1:0] HOLD_LOAD = HW'(HOLD_CYC - 1);
   localparam logic [HW-1:0] HOLD_ZERO = '0;

   // ****************************************
   // declarations
   // ****************************************
   logic run_control_r;
   logic [3:0] irq_enable_r;
   logic [3:0] event_flags_r;
   logic [3:0] event_flags_nxt;
   logic [3:0] low_r;
   logic [3:0] high_r;
   logic [3:0] low_nxt;
   logic [3:0] high_nxt;
   logic carry_pend_r;
   logic carry_pend_nxt;
   logic hold_r;
   logic [HW-1:0] hold_cnt_r;
   logic [3:0] evt;
   logic tick;
   logic access;
   logic done;
   logic wr;
   logic rd;
   logic mapped;
   logic counter_clear_strobe;
   logic advance;
   logic carry;

   generate
      // one pending carry only: a hold must end before the next carry
      if (HOLD_CYC < 1 || HOLD_CYC > HOLD_CYC_MAX
         || HOLD_CYC >= (int'(NIBBLE_MAX) + 1) * TICK_CYC)
      begin : g_chk
         $error("cktm_clock_timer: HOLD_CYC out of range");
      end
   endgenerate

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [IDX_W-1:0] idx);
      return a == {idx, 2'b00};
   endfunction

   function automatic logic [3:0] taps(input logic [7:0] c);
      return {c[TAP_1HZ], c[TAP_2HZ], c[TAP_8HZ], c[TAP_32HZ]};
   endfunction

   // ****************************************
   // apb slave: one wait state, then pready
   // ****************************************
   assign access = psel && penable;
   assign done = access && pready;
   assign wr = done && pwrite && pstrb[0];
   assign rd = done && !pwrite;
   assign mapped = hit(paddr, IDX_TIMER_CONTROL) || hit(paddr, IDX_TIMER_COUNT_LOW)
      || hit(paddr, IDX_TIMER_COUNT_HIGH) || hit(paddr, IDX_TIMER_IRQ_ENABLE)
      || hit(paddr, IDX_TIMER_IRQ_FLAGS);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pready <= 1'b0;
      else
         pready <= access && !pready;
   end

   // unmapped addresses answer with an error and no effect
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pslverr <= 1'b0;
      else
         pslverr <= access && !pready && !mapped;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= RDATA_ZERO;
      else if (access && !pready && !pwrite)
      begin
         prdata <= RDATA_ZERO;
         if (hit(paddr, IDX_TIMER_CONTROL))
            prdata[CTRL_RUN_BIT] <= run_control_r; // clear bit reads zero
         else if (hit(paddr, IDX_TIMER_COUNT_LOW))
            prdata[3:0] <= low_r;
         else if (hit(paddr, IDX_TIMER_COUNT_HIGH))
            prdata[3:0] <= high_r;
         else if (hit(paddr, IDX_TIMER_IRQ_ENABLE))
            prdata[3:0] <= irq_enable_r;
         else if (hit(paddr, IDX_TIMER_IRQ_FLAGS))
            prdata[3:0] <= event_flags_r;
      end
   end

   // ****************************************
   // control and enable registers
   // ****************************************
   assign counter_clear_strobe = wr && hit(paddr, IDX_TIMER_CONTROL) && pwdata[CTRL_CLEAR_BIT];

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         run_control_r <= 1'b0;
      else if (wr && hit(paddr, IDX_TIMER_CONTROL))
         run_control_r <= pwdata[CTRL_RUN_BIT];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_enable_r <= NIBBLE_RST;
      else if (wr && hit(paddr, IDX_TIMER_IRQ_ENABLE))
         irq_enable_r <= pwdata[3:0];
   end

   // ****************************************
   // counter with high-nibble hold
   // ****************************************
   cktm_tick_div #(
      .DIV(TICK_CYC)
   ) u_div (
      .pclk(pclk),
      .presetn(presetn),
      .restart(counter_clear_strobe),
      .tick(tick)
   );

   // a stopped timer ignores ticks; only a pending carry or a clear strobe still changes its value
   assign advance = tick && run_control_r;
   assign carry = advance && low_r == NIBBLE_MAX;

   always_comb
   begin
      low_nxt = advance ? low_r + 1'b1 : low_r;
      // a carry that meets the hold waits; only one can pend since holds are short
      carry_pend_nxt = (carry || carry_pend_r) && hold_r;
      high_nxt = ((carry || carry_pend_r) && !hold_r) ? high_r + 1'b1 : high_r;
      if (counter_clear_strobe)
      begin
         low_nxt = NIBBLE_RST;
         high_nxt = NIBBLE_RST;
         carry_pend_nxt = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         low_r <= COUNT_RST[3:0];
         high_r <= COUNT_RST[7:4];
         carry_pend_r <= 1'b0;
      end
      else
      begin
         low_r <= low_nxt; // writes to count words never reach here
         high_r <= high_nxt;
         carry_pend_r <= carry_pend_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         count_bits <= COUNT_RST;
      else
         count_bits <= {high_nxt, low_nxt};
   end

   // hold window: reading low starts it, reading high or timeout ends it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         hold_r <= 1'b0;
         hold_cnt_r <= HOLD_ZERO;
      end
      else if (rd && hit(paddr, IDX_TIMER_COUNT_LOW))
      begin
         hold_r <= 1'b1;
         hold_cnt_r <= HOLD_LOAD;
      end
      else if (rd && hit(paddr, IDX_TIMER_COUNT_HIGH))
         hold_r <= 1'b0;
      else if (hold_r)
      begin
         hold_r <= hold_cnt_r != HOLD_ZERO;
         hold_cnt_r <= hold_cnt_r - 1'b1;
      end
   end

   // ****************************************
   // event flags and interrupt request
   // ****************************************
   // only real count steps make events; a clear strobe makes none
   assign evt = counter_clear_strobe ? NIBBLE_RST
      : taps({high_r, low_r}) & ~taps({high_nxt, low_nxt});

   always_comb
   begin
      event_flags_nxt = event_flags_r;
      if (wr && hit(paddr, IDX_TIMER_IRQ_FLAGS))
         event_flags_nxt = event_flags_r & ~pwdata[3:0];
      event_flags_nxt = event_flags_nxt | evt; // set beats clear, mask ignored
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         event_flags_r <= NIBBLE_RST;
      else
         event_flags_r <= event_flags_nxt;
   end

   // level request: stays up until the flag or its enable is cleared
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         timer_irq <= 1'b0;
      else
         timer_irq <= |(event_flags_r & irq_enable_r);
   end

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_run_readback: assert property (wr && hit(paddr, IDX_TIMER_CONTROL)
      |=> run_control_r == $past(pwdata[CTRL_RUN_BIT]))
      else $error("run bit did not take written value");

   a_clear_zero: assert property (counter_clear_strobe |=> low_r == NIBBLE_RST
      && high_r == NIBBLE_RST && !carry_pend_r)
      else $error("clear strobe did not zero count");

   a_stop_retains: assert property (!run_control_r && !counter_clear_strobe
      && !carry_pend_r |=> $stable(low_r) && $stable(high_r))
      else $error("stopped count changed");

   a_ro_count: assert property (wr && (hit(paddr, IDX_TIMER_COUNT_LOW)
      || hit(paddr, IDX_TIMER_COUNT_HIGH)) && !advance && !carry_pend_r
      |=> $stable(low_r) && $stable(high_r))
      else $error("count changed on write");

   a_hold_high: assert property (hold_r && !counter_clear_strobe
      |=> $stable(high_r))
      else $error("high nibble moved during hold");

   a_hold_bound: assert property (rd && hit(paddr, IDX_TIMER_COUNT_LOW)
      |=> hold_r && hold_cnt_r == HOLD_LOAD)
      else $error("hold not started by low read");

   a_fall_sets: assert property ($fell(low_r[TAP_32HZ]) && !$past(counter_clear_strobe)
      |-> event_flags_r[0])
      else $error("32 Hz fall did not set flag");

   a_flag_w1c: assert property (wr && hit(paddr, IDX_TIMER_IRQ_FLAGS) && evt == NIBBLE_RST
      |=> (event_flags_r & $past(pwdata[3:0])) == NIBBLE_RST
      && (event_flags_r | $past(pwdata[3:0])) == ($past(event_flags_r) | $past(pwdata[3:0])))
      else $error("flag write one clear wrong");

   a_evt_sets: assert property (evt != NIBBLE_RST
      |=> (event_flags_r & $past(evt)) == $past(evt))
      else $error("event lost");

   a_irq_level: assert property (##1 timer_irq == $past(|(event_flags_r & irq_enable_r)))
      else $error("irq does not follow enabled flags");

   a_enable_rw: assert property (wr && hit(paddr, IDX_TIMER_IRQ_ENABLE)
      |=> irq_enable_r == $past(pwdata[3:0]))
      else $error("enable write lost");

   c_flag_1hz: cover property (evt[3]);
   c_irq_up: cover property (!timer_irq ##1 timer_irq);
   c_hold_timeout: cover property (hold_r ##1 !hold_r && !rd);
   c_clear_running: cover property (counter_clear_strobe && run_control_r);
endmodule
`default_nettype wire

/* File: dv/cktm_cpu_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// processor side: apb master and service code
// ****************************************
module cktm_cpu_model
   import cktm_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb master
   output logic [ADDR_W-1:0] paddr,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [DATA_W-1:0] pwdata,
   output logic [3:0] pstrb,
   input wire logic [DATA_W-1:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   initial
   begin
      paddr = '0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      pwdata = '0;
      pstrb = 4'hf;
   end

   // one transfer; holds the request until pready is sampled high
   task automatic xfer(input logic wr, input logic [IDX_W-1:0] idx,
      input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rd, output logic err);
      begin
         @(posedge pclk);
         psel <= 1'b1;
         penable <= 1'b0;
         pwrite <= wr;
         paddr <= {idx, 2'b00};
         pwdata <= wd;
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         // no cycle count assumed; only the bench timeout ends a stuck wait
         while (pready !== 1'b1)
            @(posedge pclk);
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         // released lines must not look like stale valid values
         pwdata <= ~wd;
         paddr <= ~{idx, 2'b00};
      end
   endtask

   // service routine: read the flags, then clear exactly what was seen
   task automatic service(output logic [3:0] seen);
      logic [DATA_W-1:0] rd;
      logic [DATA_W-1:0] tmp;
      logic e;
      begin
         xfer(1'b0, IDX_TIMER_IRQ_FLAGS, 32'h0000_0000, rd, e);
         seen = rd[3:0];
         xfer(1'b1, IDX_TIMER_IRQ_FLAGS, rd, tmp, e);
      end
   endtask

   // low word first so the high word is held
   task automatic read_pair(output logic [7:0] v);
      logic [DATA_W-1:0] lo;
      logic [DATA_W-1:0] hi;
      logic e;
      begin
         xfer(1'b0, IDX_TIMER_COUNT_LOW, 32'h0000_0000, lo, e);
         xfer(1'b0, IDX_TIMER_COUNT_HIGH, 32'h0000_0000, hi, e);
         v = {hi[3:0], lo[3:0]};
      end
   endtask
endmodule
`default_nettype wire

/* File: dv/cktm_clock_timer_tb.sv */
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// clock timer bench
// ****************************************
module cktm_clock_timer_tb
   import cktm_pkg::*;
;
   logic pclk;
   logic presetn;
   logic [ADDR_W-1:0] paddr;
   logic psel;
   logic penable;
   logic pwrite;
   logic [DATA_W-1:0] pwdata;
   logic [3:0] pstrb;
   logic [DATA_W-1:0] prdata;
   logic pready;
   logic pslverr;
   logic timer_irq;
   logic [7:0] count_bits;
   int err_count = 0;
   int check_count = 0;
   int cyc = 0;

   // hold kept long enough to span the high read
   cktm_clock_timer #(.TICK_CYC(8), .HOLD_CYC(8)) cktm_clock_timer_i (.pclk(pclk),
      .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .timer_irq(timer_irq), .count_bits(count_bits));
   cktm_cpu_model cktm_cpu_model_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));

   initial
   begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   task automatic results();
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 10000)
      begin
         err_count++;
         results();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         err_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] d);
      logic [DATA_W-1:0] r;
      logic e;
      cktm_cpu_model_i.xfer(1'b1, idx, d, r, e);
   endtask

   task automatic rdc(input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] exp);
      logic [DATA_W-1:0] r;
      logic e;
      cktm_cpu_model_i.xfer(1'b0, idx, 32'h0000_0000, r, e);
      check(r, exp);
   endtask

   task automatic settle();
      repeat (2) @(posedge pclk);
      #1;
   endtask

   task automatic t_reset();
      logic [DATA_W-1:0] r;
      logic e;
      rdc(IDX_TIMER_CONTROL, 32'h0000_0000);
      rdc(IDX_TIMER_COUNT_LOW, 32'h0000_0000);
      rdc(IDX_TIMER_COUNT_HIGH, 32'h0000_0000);
      rdc(IDX_TIMER_IRQ_ENABLE, 32'h0000_0000);
      rdc(IDX_TIMER_IRQ_FLAGS, 32'h0000_0000);
      cktm_cpu_model_i.xfer(1'b0, 16'h0001, 32'h0000_0000, r, e);
      check(e, 1'b1);
   endtask

   // a full wrap makes every tap fall at least once with all sources masked
   task automatic t_flags();
      logic [3:0] s;
      wr(IDX_TIMER_CONTROL, 32'h0000_0001);
      repeat (2200) @(posedge pclk);
      check(timer_irq, 1'b0);
      wr(IDX_TIMER_CONTROL, 32'h0000_0000);
      rdc(IDX_TIMER_IRQ_FLAGS, 32'h0000_000f);
      wr(IDX_TIMER_IRQ_ENABLE, 32'h0000_0001);
      rdc(IDX_TIMER_IRQ_ENABLE, 32'h0000_0001);
      settle();
      check(timer_irq, 1'b1);
      wr(IDX_TIMER_IRQ_FLAGS, 32'h0000_0000);
      rdc(IDX_TIMER_IRQ_FLAGS, 32'h0000_000f);
      wr(IDX_TIMER_IRQ_FLAGS, 32'h0000_0001);
      rdc(IDX_TIMER_IRQ_FLAGS, 32'h0000_000e);
      settle();
      check(timer_irq, 1'b0);
      wr(IDX_TIMER_IRQ_ENABLE, 32'h0000_000f);
      settle();
      check(timer_irq, 1'b1);
      cktm_cpu_model_i.service(s);
      check(s, 4'he);
      settle();
      check(timer_irq, 1'b0);
   endtask

   task automatic t_stop();
      logic [7:0] c;
      logic [7:0] v;
      #1;
      c = count_bits;
      wr(IDX_TIMER_COUNT_LOW, 32'h0000_000f);
      wr(IDX_TIMER_COUNT_HIGH, 32'h0000_000f);
      repeat (30) @(posedge pclk);
      #1;
      check(count_bits, c);
      cktm_cpu_model_i.read_pair(v);
      check(v, c);
      wr(IDX_TIMER_CONTROL, 32'h0000_0001);
      repeat (40) @(posedge pclk);
      #1;
      check(8'(count_bits - c) inside {[1:7]}, 1'b1);
   endtask

   task automatic t_clear();
      wr(IDX_TIMER_CONTROL, 32'h0000_0003);
      #1;
      check(count_bits <= 8'h01, 1'b1);
      repeat (20) @(posedge pclk);
      #1;
      check(count_bits inside {[1:4]}, 1'b1);
      wr(IDX_TIMER_CONTROL, 32'h0000_0000);
      wr(IDX_TIMER_CONTROL, 32'h0000_0002);
      rdc(IDX_TIMER_CONTROL, 32'h0000_0000);
      repeat (40) @(posedge pclk);
      #1;
      check(count_bits, 8'h00);
   endtask

   // returns at the first clock edge that finds the low nibble at its top value
   task automatic wait_low_max();
      do
      begin
         @(posedge pclk);
         #1;
      end
      while (count_bits[3:0] !== 4'hf);
   endtask

   // carry falls due between the two reads; the held high word hides it
   task automatic t_hold();
      logic [3:0] h;
      logic [DATA_W-1:0] lo;
      logic [DATA_W-1:0] hi;
      logic e;
      wr(IDX_TIMER_CONTROL, 32'h0000_0001);
      wait_low_max();
      h = count_bits[7:4];
      cktm_cpu_model_i.xfer(1'b0, IDX_TIMER_COUNT_LOW, 32'h0000_0000, lo, e);
      // gap pushes the high read past the carry, so only the hold keeps it
      repeat (2) @(posedge pclk);
      cktm_cpu_model_i.xfer(1'b0, IDX_TIMER_COUNT_HIGH, 32'h0000_0000, hi, e);
      check({hi[3:0], lo[3:0]}, {h, 4'hf});
      repeat (20) @(posedge pclk);
      #1;
      check(count_bits[7:4], 4'(h + 1));
      // a lone low read: the hold runs out and the pending carry lands
      wait_low_max();
      cktm_cpu_model_i.xfer(1'b0, IDX_TIMER_COUNT_LOW, 32'h0000_0000, lo, e);
      repeat (20) @(posedge pclk);
      #1;
      check(count_bits[7:4], 4'(h + 2));
   endtask

   initial
   begin
      presetn = 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_flags();
      t_stop();
      t_clear();
      t_hold();
      results();
   end
endmodule
`default_nettype wire
